// >>> rtl/cwp_consts.svh
`ifndef CWP_CONSTS_SVH
`define CWP_CONSTS_SVH

// ==========================================================
// Register offsets (word index on the register port)
`define CWP_ADDR_OPTIONS  2'h0
`define CWP_ADDR_SERVICE  2'h1
`define CWP_ADDR_PRIORITY 2'h2
`define CWP_ADDR_STATUS   2'h3

// ==========================================================
// Field positions of system_options
`define CWP_OPT_IRQ_EDGE   5
`define CWP_OPT_EXIT_DELAY 4
`define CWP_OPT_MON_EN     3
`define CWP_OPT_MON_FORCE  2
`define CWP_OPT_RATE_HI    1
`define CWP_OPT_RATE_LO    0

// ==========================================================
// Field positions of priority_and_misc
`define CWP_PRI_BOOT    7
`define CWP_PRI_SPECIAL 6
`define CWP_PRI_MODE_A  5
`define CWP_PRI_PSEL_HI 4

// ==========================================================
// Reset values and keys
`define CWP_OPT_RESET  8'h10
`define CWP_PSEL_RESET 5'h06
`define CWP_PSEL_IRQ   5'h06
`define CWP_KEY_ARM    8'h55
`define CWP_KEY_CLEAR  8'haa

// ==========================================================
// Timing counts in E clock cycles
`define CWP_WRITE_WINDOW   7'h40
`define CWP_WDOG_BASE_LOG2 15

`endif

// >>> rtl/cwp_pkg.sv
package cwp_pkg;

    // ==========================================================
    // Stop-exit sequencer, Gray coded from run through delay to resume
    typedef enum logic [1:0] {
        CWP_RUN    = 2'b00,
        CWP_DELAY  = 2'b01,
        CWP_RESUME = 2'b11
    } cwp_stop_state_t;

    // ==========================================================
    // Live configuration bits of system_options
    typedef struct packed {
        logic       irq_edge_select;
        logic       stop_exit_delay_en;
        logic       clk_monitor_en;
        logic       clk_monitor_force;
        logic [1:0] wdog_rate_sel;
    } cwp_options_t;

    // ==========================================================
    // Mode bits of priority_and_misc
    typedef struct packed {
        logic boot_rom_select;
        logic special_mode_select;
        logic mode_select_a;
    } cwp_mode_t;

endpackage

// >>> rtl/cwp_wdog.sv
`include "cwp_consts.svh"

module cwp_wdog
    import cwp_pkg::*;
#(
    parameter int BASE_LOG2 = `CWP_WDOG_BASE_LOG2
) (
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    input  wire logic       e_tick,
    input  wire logic       enable,
    input  wire logic [1:0] rate_sel,
    input  wire logic       svc_write,
    input  wire logic [7:0] svc_data,
    output logic            wdog_reset,
    output logic            armed
);

    // ==========================================================
    // Base prescaler and rate counter
    logic [BASE_LOG2-1:0] pre;
    logic [6:0]           ticks;
    logic [6:0]           limit;
    logic                 base_tick;
    logic                 restart;

    assign base_tick = e_tick && (pre == {BASE_LOG2{1'b1}});
    // Prescaler is not cleared by service, so allow one extra base period
    assign limit     = 7'((7'h01 << {rate_sel, 1'b0}) + 7'h01);
    assign restart   = svc_write && (svc_data == `CWP_KEY_CLEAR) && armed;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pre <= '0;
        end else if (!enable) begin
            pre <= '0;
        end else if (e_tick) begin
            pre <= pre + 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ticks <= 7'h00;
        end else if (!enable || restart) begin
            ticks <= 7'h00;
        end else if (base_tick) begin
            ticks <= (ticks + 7'h01 >= limit) ? 7'h00 : ticks + 7'h01;
        end
    end

    // ==========================================================
    // Timeout pulse
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wdog_reset <= 1'b0;
        end else begin
            wdog_reset <= enable && !restart && base_tick
                          && (ticks + 7'h01 >= limit);
        end
    end

    // ==========================================================
    // Two-key arming
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            armed <= 1'b0;
        end else if (svc_write && svc_data == `CWP_KEY_ARM) begin
            armed <= 1'b1;
        end else if (restart) begin
            armed <= 1'b0;
        end
    end

endmodule // cwp_wdog

// >>> rtl/cwp_top.sv
// What this block does
// - IRQ pin sensed low-level when edge select is 0, falling edge when 1.
// - Delay bit set inserts oscillator settle delay leaving stop; clear resumes at once.
// - Monitor enable set raises clock-failure reset on slow clock; clear tolerates it.
// - Force bit keeps the clock monitor on until next reset.
// - Watchdog timeout is E period times 2^15, 2^17, 2^19 or 2^21 by rate.
// - Writing 0x55 to the service register arms clearing, count keeps running.
// - 0xAA after arming restarts the count; software must do both each period.
// - Boot, special and mode-A bits reset from straps, writable only in special mode.
// - Priority select writable only while global interrupt mask is set.
// - Selected maskable source raised above all others, rest keep default order.
// - Codes 00110 to 01111 promote IRQ, real-time, captures and compares.
// - Codes 10000 to 10100 promote overflow, accumulator, SPI and serial interface.
// - All other codes are reserved and promote the IRQ pin source.
// - Service register reads zero; its value only serves as a key.
// - Protected option bits write once in first 64 cycles normally, anytime special.
//
// The placing of the registers and strobed register access were left to the implementer.
`include "cwp_consts.svh"

module cwp_top
    import cwp_pkg::*;
#(
    parameter int E_DIV           = 1,
    parameter int STOP_DELAY      = 4064,
    parameter int CLKMON_TIMEOUT  = 64,
    parameter int WDOG_BASE_LOG2  = `CWP_WDOG_BASE_LOG2
) (
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    input  wire logic [1:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       boot_rom_strap,
    input  wire logic       special_mode_strap,
    input  wire logic       mode_a_strap,
    input  wire logic       wdog_disable_cfg,
    input  wire logic       int_mask_set,
    input  wire logic       irq_pin,
    input  wire logic       irq_ack,
    input  wire logic       stop_exit,
    input  wire logic       osc_alive,
    output logic            irq_request,
    output logic            stop_resume,
    output logic            wdog_reset,
    output logic            clk_fail_reset,
    output logic      [4:0] promoted_src
);

    // ==========================================================
    // E clock enable divider
    logic [15:0]   e_div_cnt;
    logic          e_tick;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            e_div_cnt <= 16'h0000;
            e_tick    <= 1'b0;
        end else if (e_div_cnt >= 16'(E_DIV - 1)) begin
            e_div_cnt <= 16'h0000;
            e_tick    <= 1'b1;
        end else begin
            e_div_cnt <= e_div_cnt + 16'h0001;
            e_tick    <= 1'b0;
        end
    end

    // ==========================================================
    // Register state
    cwp_options_t  opts;
    cwp_mode_t     mode;
    logic [4:0]    psel;
    logic          straps_taken;
    logic [6:0]    window_cnt;
    logic          opt_written;
    logic          wr_opt;
    logic          wr_svc;
    logic          wr_pri;
    logic          window_open;
    logic          special;
    logic          protected_ok;
    logic          armed;

    assign wr_opt       = reg_wr && reg_addr == `CWP_ADDR_OPTIONS;
    assign wr_svc       = reg_wr && reg_addr == `CWP_ADDR_SERVICE;
    assign wr_pri       = reg_wr && reg_addr == `CWP_ADDR_PRIORITY;
    assign special      = mode.special_mode_select;
    assign window_open  = window_cnt < `CWP_WRITE_WINDOW;
    assign protected_ok = special || (window_open && !opt_written);

    // Counts E cycles up to the end of the write-once window
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            window_cnt <= 7'h00;
        end else if (e_tick && window_open) begin
            window_cnt <= window_cnt + 7'h01;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            opt_written <= 1'b0;
        end else if (wr_opt && !special) begin
            opt_written <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            opts <= cwp_options_t'(`CWP_OPT_RESET);
        end else if (wr_opt) begin
            opts.clk_monitor_en <= reg_wdata[`CWP_OPT_MON_EN];
            if (protected_ok) begin
                opts.irq_edge_select    <= reg_wdata[`CWP_OPT_IRQ_EDGE];
                opts.stop_exit_delay_en <= reg_wdata[`CWP_OPT_EXIT_DELAY];
                opts.wdog_rate_sel      <= reg_wdata[`CWP_OPT_RATE_HI:`CWP_OPT_RATE_LO];
                // Force can only be set; it clears on reset alone
                opts.clk_monitor_force  <= opts.clk_monitor_force
                                           | reg_wdata[`CWP_OPT_MON_FORCE];
            end
        end
    end

    // Straps are caught by the clock after release, not by the reset itself
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            straps_taken <= 1'b0;
            mode         <= '0;
        end else if (!straps_taken) begin
            straps_taken <= 1'b1;
            mode         <= '{boot_rom_strap, special_mode_strap, mode_a_strap};
        end else if (wr_pri && special) begin
            mode <= '{reg_wdata[`CWP_PRI_BOOT], reg_wdata[`CWP_PRI_SPECIAL],
                      reg_wdata[`CWP_PRI_MODE_A]};
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            psel <= `CWP_PSEL_RESET;
        end else if (wr_pri && int_mask_set) begin
            psel <= reg_wdata[`CWP_PRI_PSEL_HI:0];
        end
    end

    // ==========================================================
    // Priority promotion
    // Only the promoted code leaves here; the prioritiser keeps its default
    // order for the rest, so one code is all it needs
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            promoted_src <= `CWP_PSEL_IRQ;
        end else if (psel >= 5'h06 && psel <= 5'h14) begin
            promoted_src <= psel;
        end else begin
            promoted_src <= `CWP_PSEL_IRQ;
        end
    end

    // ==========================================================
    // External interrupt sensing
    logic irq_pin_q;
    logic irq_edge_hit;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irq_pin_q <= 1'b1;
        end else begin
            irq_pin_q <= irq_pin;
        end
    end

    assign irq_edge_hit = irq_pin_q && !irq_pin;

    // A falling edge in the acknowledge cycle is kept
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irq_request <= 1'b0;
        end else if (!opts.irq_edge_select) begin
            irq_request <= !irq_pin;
        end else if (irq_edge_hit) begin
            irq_request <= 1'b1;
        end else if (irq_ack) begin
            irq_request <= 1'b0;
        end
    end

    // ==========================================================
    // Stop exit sequencer
    cwp_stop_state_t stop_state;
    logic [15:0]     stop_cnt;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            stop_state <= CWP_RUN;
            stop_cnt   <= 16'h0000;
        end else begin
            case (stop_state)
                CWP_RUN: begin
                    stop_cnt <= 16'h0000;
                    if (stop_exit) begin
                        stop_state <= opts.stop_exit_delay_en ? CWP_DELAY : CWP_RESUME;
                    end
                end
                CWP_DELAY: begin
                    if (e_tick) begin
                        stop_cnt <= stop_cnt + 16'h0001;
                    end
                    if (stop_cnt >= 16'(STOP_DELAY)) begin
                        stop_state <= CWP_RESUME;
                    end
                end
                CWP_RESUME: begin
                    stop_state <= CWP_RUN;
                end
                default: begin
                    stop_state <= CWP_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            stop_resume <= 1'b0;
        end else begin
            stop_resume <= (stop_state == CWP_DELAY && stop_cnt >= 16'(STOP_DELAY))
                           || (stop_state == CWP_RUN && stop_exit
                               && !opts.stop_exit_delay_en);
        end
    end

    // ==========================================================
    // Clock monitor
    // The oscillator is seen only through its alive pulse; a gap longer
    // than the timeout counts as a slow or stopped clock
    logic        mon_on;
    logic [15:0] mon_cnt;

    assign mon_on = opts.clk_monitor_en || opts.clk_monitor_force;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mon_cnt <= 16'h0000;
        end else if (!mon_on || osc_alive) begin
            mon_cnt <= 16'h0000;
        end else if (mon_cnt < 16'(CLKMON_TIMEOUT)) begin
            mon_cnt <= mon_cnt + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            clk_fail_reset <= 1'b0;
        end else begin
            clk_fail_reset <= mon_on && !osc_alive
                              && mon_cnt >= 16'(CLKMON_TIMEOUT - 1);
        end
    end

    // ==========================================================
    // Watchdog
    cwp_wdog #(
        .BASE_LOG2 (WDOG_BASE_LOG2)
    ) u_wdog (
        .sys_clk    (sys_clk),
        .rstn       (rstn),
        .e_tick     (e_tick),
        .enable     (!wdog_disable_cfg),
        .rate_sel   (opts.wdog_rate_sel),
        .svc_write  (wr_svc),
        .svc_data   (reg_wdata),
        .wdog_reset (wdog_reset),
        .armed      (armed)
    );

    // ==========================================================
    // Read port
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `CWP_ADDR_OPTIONS: begin
                    reg_rdata <= {2'b00, opts};
                end
                `CWP_ADDR_SERVICE: begin
                    reg_rdata <= 8'h00;
                end
                `CWP_ADDR_PRIORITY: begin
                    reg_rdata <= {mode, psel};
                end
                `CWP_ADDR_STATUS: begin
                    reg_rdata <= {3'b000, opt_written, mon_on, armed,
                                  stop_state != CWP_RUN, irq_request};
                end
                default: begin
                    reg_rdata <= 8'h00;
                end
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule // cwp_top

// >>> testbench/cwp_top_asserts.sv
module cwp_top_asserts
    import cwp_pkg::*;
#(
    parameter int E_DIV          = 1,
    parameter int STOP_DELAY     = 4064,
    parameter int CLKMON_TIMEOUT = 64,
    parameter int WDOG_BASE_LOG2 = 15
) (
    input wire logic       sys_clk,
    input wire logic       rstn,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       boot_rom_strap,
    input wire logic       special_mode_strap,
    input wire logic       mode_a_strap,
    input wire logic       wdog_disable_cfg,
    input wire logic       int_mask_set,
    input wire logic       irq_pin,
    input wire logic       irq_ack,
    input wire logic       stop_exit,
    input wire logic       osc_alive,
    input wire logic       irq_request,
    input wire logic       stop_resume,
    input wire logic       wdog_reset,
    input wire logic       clk_fail_reset,
    input wire logic [4:0] promoted_src
);
    // ==========================================================
    // Helpers
    logic       psel_wr;
    logic [7:0] quiet;
    logic [4:0] exp_map;

    assign psel_wr = reg_wr && reg_addr == 2'h2 && int_mask_set;
    // Reserved codes fall back to the external pin source
    assign exp_map = (reg_wdata[4:0] inside {[5'h06:5'h14]}) ? reg_wdata[4:0] : 5'h06;

    // Saturates so a long silence cannot wrap back to zero
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            quiet <= 8'h0;
        else if (osc_alive)
            quiet <= 8'h0;
        else if (quiet != 8'hff)
            quiet <= quiet + 8'h1;
    end

    // ==========================================================
    // Properties
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    property p_map;
        psel_wr |-> ##2 promoted_src == $past(exp_map, 2);
    endproperty

    AST_SVC_READ: assert property (reg_rd && reg_addr == 2'h1 |=> reg_rdata == 8'h0)
        else $error("service read not zero");
    AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h0)
        else $error("read data outside read cycle");
    AST_PSEL_HOLD: assert property (!psel_wr [*2] |=> $stable(promoted_src))
        else $error("promoted source moved without write");
    AST_PSEL_RANGE: assert property (promoted_src inside {[5'h06:5'h14]})
        else $error("promoted source out of range");
    AST_PSEL_MAP: assert property (p_map)
        else $error("promoted source mismatch");
    AST_WDOG_GAP: assert property (wdog_reset |=> !wdog_reset [*7])
        else $error("watchdog timeout too short");
    AST_WDOG_OFF: assert property (wdog_disable_cfg [*3] |-> !wdog_reset)
        else $error("watchdog fired while disabled");
    AST_STOP_PULSE: assert property (stop_resume |=> !stop_resume)
        else $error("resume pulse too long");
    AST_CLKFAIL_CLEAR: assert property (osc_alive |=> !clk_fail_reset)
        else $error("clock failure kept with live clock");
    AST_CLKFAIL_QUIET: assert property ($rose(clk_fail_reset) |->
            quiet >= CLKMON_TIMEOUT - 1)
        else $error("clock failure too early");

    cover property (wdog_reset);
    cover property ($rose(clk_fail_reset));
    cover property (psel_wr ##2 promoted_src != 5'h06);
endmodule // cwp_top_asserts

bind cwp_top cwp_top_asserts #(
    .E_DIV          (E_DIV),
    .STOP_DELAY     (STOP_DELAY),
    .CLKMON_TIMEOUT (CLKMON_TIMEOUT),
    .WDOG_BASE_LOG2 (WDOG_BASE_LOG2)
) u_asserts (.*);

// >>> testbench/cwp_top_bench.sv
module cwp_top_bench;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Signals
    logic       sys_clk = 1'b0;
    logic       rstn, reg_wr, reg_rd, boot_rom_strap, special_mode_strap, mode_a_strap;
    logic       wdog_disable_cfg, int_mask_set, irq_pin, irq_ack, stop_exit, osc_alive;
    logic       irq_request, stop_resume, wdog_reset, clk_fail_reset, osc_run;
    logic [1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic [4:0] promoted_src;
    logic [7:0] keys [2] = '{8'h55, 8'haa};
    logic [7:0] exp_src;
    int         n_fail = 0, check_count = 0, cyc = 0, n_wdog = 0, base_wdog = 0, n;

    // Short counts keep the run small
    cwp_top #(.E_DIV(1), .STOP_DELAY(8), .CLKMON_TIMEOUT(8), .WDOG_BASE_LOG2(3)) u_dut (.*);

    always #2 sys_clk = ~sys_clk;

    // Oscillator activity every fourth cycle while running
    always @(posedge sys_clk) begin
        osc_alive <= osc_run && cyc[1:0] == 2'h0;
        cyc <= cyc + 1;
        if (wdog_reset === 1'b1)
            n_wdog <= n_wdog + 1;
        if (cyc == 3000) begin
            n_fail++;
            $display("Error timeout expected finish seen hang");
            test_done();
        end
    end

    // ==========================================================
    // Tasks
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        tick(1);
        reg_wr <= 1'b0;
        // New step, so a following write never re-raises the strobe in this one
        tick(0);
    endtask

    task automatic rd(input logic [1:0] a, input logic [7:0] exp, input string what);
        reg_addr <= a;
        reg_rd <= 1'b1;
        tick(1);
        reg_rd <= 1'b0;
        tick(0);
        chk(what, exp, reg_rdata);
    endtask

    task automatic wait_hi(ref logic s, input int lim);
        n = 0;
        while (s !== 1'b1 && n < lim) begin
            tick(1);
            n++;
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ==========================================================
    // Sequence
    initial begin
        {rstn, reg_wr, reg_rd, boot_rom_strap, special_mode_strap, wdog_disable_cfg} = '0;
        {int_mask_set, irq_ack, stop_exit, reg_addr, reg_wdata} = '0;
        {mode_a_strap, irq_pin, osc_run} = '1;
        tick(20);
        rstn <= 1'b1;
        tick(2);
        rd(2'h0, 8'h10, "options_reset");
        rd(2'h1, 8'h00, "service_reset");
        rd(2'h2, 8'h26, "priority_reset");
        irq_pin <= 1'b0;
        tick(2);
        chk("irq_level", 8'h1, {7'h0, irq_request});
        irq_ack <= 1'b1;
        tick(1);
        irq_ack <= 1'b0;
        tick(1);
        chk("irq_level_held", 8'h1, {7'h0, irq_request});
        irq_pin <= 1'b1;
        tick(2);
        chk("irq_level_off", 8'h0, {7'h0, irq_request});
        stop_exit <= 1'b1;
        tick(1);
        stop_exit <= 1'b0;
        wait_hi(stop_resume, 40);
        chk("stop_delay", 8'h1, {7'h0, n >= 7 && n <= 10});
        osc_run <= 1'b0;
        tick(14);
        chk("monitor_off", 8'h0, {7'h0, clk_fail_reset});
        osc_run <= 1'b1;
        wr(2'h0, 8'h2c);
        wr(2'h0, 8'h13);
        rd(2'h0, 8'h24, "options_once");
        $display("test reset_and_options done");
        osc_run <= 1'b0;
        tick(14);
        chk("monitor_forced", 8'h1, {7'h0, clk_fail_reset});
        osc_run <= 1'b1;
        tick(6);
        chk("monitor_recover", 8'h0, {7'h0, clk_fail_reset});
        stop_exit <= 1'b1;
        tick(1);
        stop_exit <= 1'b0;
        chk("stop_nodelay", 8'h1, {7'h0, stop_resume});
        irq_pin <= 1'b0;
        tick(2);
        chk("irq_edge", 8'h1, {7'h0, irq_request});
        irq_ack <= 1'b1;
        tick(1);
        irq_ack <= 1'b0;
        tick(2);
        chk("irq_edge_ack", 8'h0, {7'h0, irq_request});
        irq_pin <= 1'b1;
        $display("test monitor_stop_irq done");
        wr(2'h1, 8'h55);
        wr(2'h1, 8'haa);
        wait_hi(wdog_reset, 40);
        chk("wdog_timeout", 8'h1, {7'h0, n >= 8 && n <= 17});
        tick(2);
        base_wdog = n_wdog;
        repeat (8) begin
            wr(2'h1, 8'h55);
            wr(2'h1, 8'h3c);
            wr(2'h1, 8'haa);
            tick(3);
        end
        chk("wdog_serviced", 8'h0, 8'(n_wdog - base_wdog));
        foreach (keys[i]) begin
            base_wdog = n_wdog;
            repeat (8) begin
                wr(2'h1, keys[i]);
                tick(4);
            end
            chk("wdog_one_key", 8'h1, {7'h0, n_wdog > base_wdog});
        end
        wdog_disable_cfg <= 1'b1;
        tick(2);
        base_wdog = n_wdog;
        tick(40);
        chk("wdog_disabled", 8'h0, 8'(n_wdog - base_wdog));
        $display("test watchdog done");
        wr(2'h2, 8'h07);
        rd(2'h2, 8'h26, "psel_locked");
        int_mask_set <= 1'b1;
        for (int c = 0; c < 32; c++) begin
            wr(2'h2, {3'b110, c[4:0]});
            rd(2'h2, {3'b001, c[4:0]}, "psel_field");
            exp_src = {3'h0, (c >= 6 && c <= 20) ? c[4:0] : 5'h06};
            chk("promoted", exp_src, {3'h0, promoted_src});
        end
        $display("test priority done");
        rstn <= 1'b0;
        special_mode_strap <= 1'b1;
        wdog_disable_cfg <= 1'b0;
        tick(2);
        rstn <= 1'b1;
        tick(2);
        wr(2'h0, 8'h2c);
        wr(2'h0, 8'h01);
        rd(2'h0, 8'h05, "options_special");
        rd(2'h2, 8'h66, "priority_strap");
        wr(2'h2, 8'ha7);
        rd(2'h2, 8'ha7, "priority_special");
        wr(2'h1, 8'h55);
        rd(2'h3, 8'h0c, "status_armed");
        wr(2'h1, 8'haa);
        wait_hi(wdog_reset, 60);
        chk("wdog_rate1", 8'h1, {7'h0, n >= 32 && n <= 41});
        $display("test special_mode done");
        rstn <= 1'b0;
        special_mode_strap <= 1'b0;
        tick(2);
        rstn <= 1'b1;
        tick(70);
        wr(2'h0, 8'h2f);
        rd(2'h0, 8'h18, "options_late");
        $display("test write_window done");
        test_done();
    end
endmodule // cwp_top_bench
